// ==== dcs_cfg.svh ====
// register offsets, reset values and limits for the command source selector
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
// ==========================================
// register indices as they appear on the plain index bus, no byte scaling
`define DCS_IDX_SPEED_SRC 12'h1a0
`define DCS_IDX_RUN_SRC 12'h1a1
`define DCS_IDX_STOP_METHOD 12'h1a2
`define DCS_IDX_STATUS 12'h1a3
// ==========================================
// reset values and limits
`define DCS_SPEED_SRC_RST 16'h0003
`define DCS_RUN_SRC_RST 16'h0003
`define DCS_STOP_METHOD_RST 16'h0001
`define DCS_SRC_MAX 16'h0003
`define DCS_STOP_MAX 16'h0001
`endif

// ==== dcs_pkg.sv ====
// types shared by the command source selector
package dcs_pkg;
    // ==========================================
    // source encodings
    typedef enum logic [1:0] {
        DCS_SRC_PANEL = 2'b00,
        DCS_SRC_TERMINAL = 2'b01,
        DCS_SRC_SERIAL = 2'b10,
        DCS_SRC_CONTROLLER = 2'b11
    } dcs_src_t;
    // ==========================================
    // drive run state
    typedef enum logic [1:0] {
        DCS_ST_STOPPED = 2'b00,
        DCS_ST_RUNNING = 2'b01,
        DCS_ST_RAMP_STOP = 2'b10
    } dcs_state_t;
endpackage : dcs_pkg

// ==== dcs_regs.sv ====
// configuration register file: source and stop method selections
`include "dcs_cfg.svh"
module dcs_regs (
    input wire logic mclk_in, // controller clock
    input wire logic srst_in, // sync reset, high
    input wire logic wr_en_in, // write strobe
    input wire logic [11:0] addr_in, // register index
    input wire logic [15:0] wdata_in, // write data
    input wire logic running_in, // drive is running
    output logic [1:0] speed_src_out, // speed source
    output logic [1:0] run_src_out, // run source
    output logic stop_coast_out // 1 coast, 0 ramp
);
    logic [1:0] speed_src_reg, speed_src_next;
    logic [1:0] run_src_reg, run_src_next;
    logic stop_reg, stop_next;
    // ==========================================
    // write decode; writes ignored while running or out of range
    always_comb begin
        speed_src_next = speed_src_reg;
        run_src_next = run_src_reg;
        stop_next = stop_reg;
        if (wr_en_in && !running_in) begin
            if (addr_in == `DCS_IDX_SPEED_SRC && wdata_in <= `DCS_SRC_MAX) begin
                speed_src_next = wdata_in[1:0];
            end
            if (addr_in == `DCS_IDX_RUN_SRC && wdata_in <= `DCS_SRC_MAX) begin
                run_src_next = wdata_in[1:0];
            end
            if (addr_in == `DCS_IDX_STOP_METHOD && wdata_in <= `DCS_STOP_MAX) begin
                stop_next = wdata_in[0];
            end
        end
    end
    // registers with documented reset values
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            speed_src_reg <= 2'(`DCS_SPEED_SRC_RST);
            run_src_reg <= 2'(`DCS_RUN_SRC_RST);
            stop_reg <= 1'(`DCS_STOP_METHOD_RST);
        end else begin
            speed_src_reg <= speed_src_next;
            run_src_reg <= run_src_next;
            stop_reg <= stop_next;
        end
    end
    assign speed_src_out = speed_src_reg;
    assign run_src_out = run_src_reg;
    assign stop_coast_out = stop_reg;
    // ==========================================
    // assertions
    AST_NO_CHANGE_RUNNING: assert property (@(posedge mclk_in) disable iff (srst_in)
        running_in |=> $stable(speed_src_reg) && $stable(run_src_reg) && $stable(stop_reg))
        else $error("selection changed while running");
    AST_RANGE_REJECT: assert property (@(posedge mclk_in) disable iff (srst_in)
        (wr_en_in && addr_in == `DCS_IDX_RUN_SRC && wdata_in > `DCS_SRC_MAX) |=> $stable(run_src_reg))
        else $error("out of range run source accepted");
endmodule : dcs_regs

// ==== dcs_top.sv ====
// drive command source selector: reference and run command multiplexing, stop handling
// Functional notes
// - speed source 0 panel, 1 analog terminal, 2 serial, 3 controller.
// - speed source resets to 3 and is frozen while running.
// - source 0 takes speed from the panel reference setting only.
// - source 1 takes speed from the first analog input sample.
// - run source 0..3 decoded, resets to 3, frozen while running.
// - run source 0 uses panel run, stop, inch and direction keys.
// - run source 1 uses terminal sequence run and reverse inputs.
// - stop command stops output by ramp or coast per selection.
// - stop method 0 ramp, 1 coast; resets to 1; frozen running.
`include "dcs_cfg.svh"
module dcs_top #(
    parameter int REF_W = 16 // speed reference width
) (
    input wire logic mclk_in, // controller clock, 40 MHz
    input wire logic srst_in, // sync reset, high
    input wire logic wr_en_in, // register write strobe
    input wire logic rd_en_in, // register read strobe
    input wire logic [11:0] addr_in, // register index
    input wire logic [15:0] wdata_in, // write data
    output logic [15:0] rdata_out, // read data
    input wire logic [REF_W-1:0] panel_ref_in, // panel reference setting
    input wire logic [REF_W-1:0] first_analog_input_in, // analog sample
    input wire logic [REF_W-1:0] serial_ref_in, // serial link reference
    input wire logic [REF_W-1:0] ctrl_ref_in, // controller reference
    input wire logic panel_run_key_in, // panel run key pulse
    input wire logic panel_stop_key_in, // panel stop key pulse
    input wire logic inch_key_in, // panel inch key level
    input wire logic direction_toggle_key_in, // panel direction pulse
    input wire logic term_run_in, // terminal run level
    input wire logic term_rev_in, // terminal reverse level
    input wire logic serial_run_in, // serial run level
    input wire logic serial_rev_in, // serial reverse level
    input wire logic ctrl_run_in, // controller run level
    input wire logic ctrl_rev_in, // controller reverse level
    input wire logic ramp_done_in, // ramp reached zero
    output logic [REF_W-1:0] speed_ref_out, // selected reference
    output logic run_out, // output active
    output logic reverse_out, // reverse direction
    output logic inch_out, // inching in progress
    output logic decel_out, // ramping down to stop
    output logic coast_out // one-cycle pulse when a coasting stop cuts the output
);
    logic [1:0] speed_src;
    logic [1:0] run_src;
    logic stop_coast;
    logic running;
    // ==========================================
    // configuration registers
    dcs_regs dcs_regs_inst (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .wr_en_in(wr_en_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .running_in(running),
        .speed_src_out(speed_src),
        .run_src_out(run_src),
        .stop_coast_out(stop_coast)
    );
    dcs_pkg::dcs_state_t state_reg, state_next;
    logic [REF_W-1:0] ref_reg, ref_next;
    logic panel_dir_reg, panel_dir_next;
    logic run_req, rev_req, inch_req;
    logic run_reg, rev_reg, inch_reg, decel_reg, coast_reg;
    logic run_next, rev_next, inch_next, decel_next, coast_next;
    logic [15:0] rdata_reg, rdata_next;
    // ramp stop still counts as running so selections stay frozen
    assign running = (state_reg != dcs_pkg::DCS_ST_STOPPED);
    // ==========================================
    // reference multiplexer
    always_comb begin
        unique case (dcs_pkg::dcs_src_t'(speed_src))
            dcs_pkg::DCS_SRC_PANEL: ref_next = panel_ref_in;
            dcs_pkg::DCS_SRC_TERMINAL: ref_next = first_analog_input_in;
            dcs_pkg::DCS_SRC_SERIAL: ref_next = serial_ref_in;
            dcs_pkg::DCS_SRC_CONTROLLER: ref_next = ctrl_ref_in;
        endcase
    end
    // ==========================================
    // run request multiplexer; panel run, stop and direction keys are pulses, inch key and others levels
    always_comb begin
        panel_dir_next = panel_dir_reg;
        if (direction_toggle_key_in && !running) begin
            panel_dir_next = !panel_dir_reg;
        end
        run_req = 1'b0;
        rev_req = 1'b0;
        inch_req = 1'b0;
        unique case (dcs_pkg::dcs_src_t'(run_src))
            dcs_pkg::DCS_SRC_PANEL: begin
                // a run key latches run; stop key wins over it
                // an inch start must not latch, or inching would outlive the key
                run_req = (panel_run_key_in || (run_reg && !decel_reg && !inch_reg))
                          && !panel_stop_key_in;
                inch_req = inch_key_in && !panel_stop_key_in;
                rev_req = panel_dir_reg;
            end
            dcs_pkg::DCS_SRC_TERMINAL: begin
                run_req = term_run_in;
                rev_req = term_rev_in;
            end
            dcs_pkg::DCS_SRC_SERIAL: begin
                run_req = serial_run_in;
                rev_req = serial_rev_in;
            end
            dcs_pkg::DCS_SRC_CONTROLLER: begin
                run_req = ctrl_run_in;
                rev_req = ctrl_rev_in;
            end
        endcase
    end
    // ==========================================
    // run and stop state machine
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dcs_pkg::DCS_ST_STOPPED: begin
                if (run_req || inch_req) begin
                    state_next = dcs_pkg::DCS_ST_RUNNING;
                end
            end
            dcs_pkg::DCS_ST_RUNNING: begin
                if (!run_req && !inch_req) begin
                    state_next = stop_coast ? dcs_pkg::DCS_ST_STOPPED
                                            : dcs_pkg::DCS_ST_RAMP_STOP;
                end
            end
            dcs_pkg::DCS_ST_RAMP_STOP: begin
                if (ramp_done_in) begin
                    state_next = dcs_pkg::DCS_ST_STOPPED;
                end else if (run_req || inch_req) begin
                    state_next = dcs_pkg::DCS_ST_RUNNING;
                end
            end
            default: state_next = dcs_pkg::DCS_ST_STOPPED;
        endcase
        run_next = (state_next != dcs_pkg::DCS_ST_STOPPED);
        decel_next = (state_next == dcs_pkg::DCS_ST_RAMP_STOP);
        // coast flag marks the cycle a coasting stop cut the output
        coast_next = (state_reg == dcs_pkg::DCS_ST_RUNNING)
                     && (state_next == dcs_pkg::DCS_ST_STOPPED);
        // direction tracks request every cycle while stopped, held from start through ramp stop
        rev_next = (state_reg == dcs_pkg::DCS_ST_STOPPED) ? rev_req : rev_reg;
        inch_next = inch_req && !run_req && (state_next == dcs_pkg::DCS_ST_RUNNING);
    end
    // ==========================================
    // register read mux; unmapped index reads zero
    always_comb begin
        rdata_next = 16'h0000;
        if (rd_en_in) begin
            unique case (addr_in)
                `DCS_IDX_SPEED_SRC: rdata_next = {14'h0000, speed_src};
                `DCS_IDX_RUN_SRC: rdata_next = {14'h0000, run_src};
                `DCS_IDX_STOP_METHOD: rdata_next = {15'h0000, stop_coast};
                `DCS_IDX_STATUS: rdata_next = {13'h0000, decel_reg, rev_reg, run_reg};
                default: rdata_next = 16'h0000;
            endcase
        end
    end
    // ==========================================
    // state registers
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= dcs_pkg::DCS_ST_STOPPED;
            ref_reg <= '0;
            panel_dir_reg <= 1'b0;
            run_reg <= 1'b0;
            rev_reg <= 1'b0;
            inch_reg <= 1'b0;
            decel_reg <= 1'b0;
            coast_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            ref_reg <= ref_next;
            panel_dir_reg <= panel_dir_next;
            run_reg <= run_next;
            rev_reg <= rev_next;
            inch_reg <= inch_next;
            decel_reg <= decel_next;
            coast_reg <= coast_next;
            rdata_reg <= rdata_next;
        end
    end
    assign speed_ref_out = ref_reg;
    assign run_out = run_reg;
    assign reverse_out = rev_reg;
    assign inch_out = inch_reg;
    assign decel_out = decel_reg;
    assign coast_out = coast_reg;
    assign rdata_out = rdata_reg;
    // ==========================================
    // assertions
    AST_PANEL_REF: assert property (@(posedge mclk_in) disable iff (srst_in)
        (speed_src == 2'h0) |=> (speed_ref_out == $past(panel_ref_in)))
        else $error("panel reference not selected");
    AST_ANALOG_REF: assert property (@(posedge mclk_in) disable iff (srst_in)
        (speed_src == 2'h1) |=> (speed_ref_out == $past(first_analog_input_in)))
        else $error("analog reference not selected");
    AST_SERIAL_REF: assert property (@(posedge mclk_in) disable iff (srst_in)
        (speed_src == 2'h2) |=> (speed_ref_out == $past(serial_ref_in)))
        else $error("serial reference not selected");
    AST_PANEL_STOP: assert property (@(posedge mclk_in) disable iff (srst_in)
        (run_src == 2'h0 && panel_stop_key_in && run_reg && !decel_reg)
        |=> (!run_out || decel_out))
        else $error("panel stop ignored");
    // inching must last as long as the key is held
    AST_INCH_HOLD: assert property (@(posedge mclk_in) disable iff (srst_in)
        (run_src == 2'h0 && inch_key_in && inch_out && !panel_run_key_in && !panel_stop_key_in)
        |=> inch_out)
        else $error("inching dropped while key held");
    AST_TERM_RUN: assert property (@(posedge mclk_in) disable iff (srst_in)
        (run_src == 2'h1 && term_run_in && state_reg == dcs_pkg::DCS_ST_STOPPED) |=> run_out)
        else $error("terminal run ignored");
    AST_COAST_STOP: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_reg == dcs_pkg::DCS_ST_RUNNING && stop_coast && !run_req && !inch_req)
        |=> (coast_out && !run_out) ##1 !coast_out)
        else $error("coast stop wrong");
    AST_RAMP_STOP: assert property (@(posedge mclk_in) disable iff (srst_in)
        (state_reg == dcs_pkg::DCS_ST_RUNNING && !stop_coast && !run_req && !inch_req)
        |=> (decel_out && run_out && !coast_out))
        else $error("ramp stop wrong");
    AST_RESET_SRC: assert property (@(posedge mclk_in)
        $past(srst_in) |-> (speed_src == 2'h3 && run_src == 2'h3 && stop_coast))
        else $error("reset selection wrong");
endmodule : dcs_top

// ==== dcs_far_side_model.sv ====
// far side model: load and ramp generator that reports zero speed after a set time
module dcs_far_side_model (
    input wire logic mclk_in, // controller clock
    input wire logic srst_in, // sync reset, high
    input wire logic decel_in, // drive ramping down
    input wire logic slow_in, // long ramp when high
    output logic ramp_done_out // ramp reached zero
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt_reg;
    // ==========================================
    // ramp timer: counts only while the drive ramps, so a stale done never leaks
    always_ff @(posedge mclk_in) begin
        if (srst_in || !decel_in) begin
            cnt_reg <= 8'h00;
        end else if (cnt_reg != 8'hff) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // done follows the ramp request; slow load takes 20 cycles, quick one 2
    assign ramp_done_out = decel_in && (cnt_reg >= (slow_in ? 8'h14 : 8'h02));
endmodule : dcs_far_side_model

// ==== drive_command_source_select_bench.sv ====
// self-checking bench for the command source selector
`include "dcs_cfg.svh"
module drive_command_source_select_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, srst_in = 1'b1, wr_en = 1'b0, rd_en = 1'b0, slow = 1'b0, inch = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000, rdata, sref;
    logic [2:0] keys = 3'b000;
    logic t_run = 1'b0, t_rev = 1'b0, s_run = 1'b0, s_rev = 1'b0, c_run = 1'b0, c_rev = 1'b0;
    logic run, rev, inch_o, decel, coast, rdone;
    int bad_count = 0, checks = 0, coast_seen = 0, c0;
    typedef struct {logic [1:0] src; logic [15:0] exp; logic rv;} dcs_row_t;
    dcs_row_t rows [4] = '{'{2'd0, 16'h1111, 1'b0}, '{2'd1, 16'h2222, 1'b1},
        '{2'd2, 16'h3333, 1'b0}, '{2'd3, 16'h4444, 1'b1}};
    // ==========================================
    // clock and instances
    always #12.5 mclk = ~mclk;
    dcs_top dcs_top_inst (.mclk_in(mclk), .srst_in(srst_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .panel_ref_in(16'h1111),
        .first_analog_input_in(16'h2222), .serial_ref_in(16'h3333), .ctrl_ref_in(16'h4444),
        .panel_run_key_in(keys[0]), .panel_stop_key_in(keys[1]), .inch_key_in(inch),
        .direction_toggle_key_in(keys[2]), .term_run_in(t_run), .term_rev_in(t_rev),
        .serial_run_in(s_run), .serial_rev_in(s_rev), .ctrl_run_in(c_run), .ctrl_rev_in(c_rev),
        .ramp_done_in(rdone), .speed_ref_out(sref), .run_out(run), .reverse_out(rev),
        .inch_out(inch_o), .decel_out(decel), .coast_out(coast));
    dcs_far_side_model dcs_far_side_model_inst (.mclk_in(mclk), .srst_in(srst_in),
        .decel_in(decel), .slow_in(slow), .ramp_done_out(rdone));
    // coast is a one-cycle pulse, so count every edge it is seen high
    always @(posedge mclk) begin
        if (coast === 1'b1) coast_seen++;
    end
    // ==========================================
    // shared tasks
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr_en <= 1'b1; addr <= a; wdata <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask : wr
    // read data is registered at the strobe edge, so look just after it
    task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string nm);
        @(posedge mclk);
        rd_en <= 1'b1; addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask : rd
    task automatic lv(input logic [1:0] s, input logic go, input logic rv);
        @(posedge mclk);
        t_run <= go && s == 2'd1; t_rev <= rv && s == 2'd1;
        s_run <= go && s == 2'd2; s_rev <= rv && s == 2'd2;
        c_run <= go && s == 2'd3; c_rev <= rv && s == 2'd3;
    endtask : lv
    task automatic press(input logic [2:0] k);
        @(posedge mclk);
        keys <= k;
        @(posedge mclk);
        keys <= 3'b000;
    endtask : press
    task automatic give_verdict;
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    // ==========================================
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        give_verdict();
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        srst_in <= 1'b0;
        #1;
        chk("run_in_reset", 16'h0000, {15'h0000, run});
        rd(`DCS_IDX_SPEED_SRC, 16'h0003, "speed_src_rst");
        rd(`DCS_IDX_RUN_SRC, 16'h0003, "run_src_rst");
        rd(`DCS_IDX_STOP_METHOD, 16'h0001, "stop_rst");
        // ordinary cases: every source for reference, sources 1 to 3 for run, coast stop
        foreach (rows[i]) begin
            wr(`DCS_IDX_SPEED_SRC, {14'h0000, rows[i].src});
            wr(`DCS_IDX_RUN_SRC, {14'h0000, rows[i].src});
            cyc(3);
            chk("speed_ref", rows[i].exp, sref);
            if (rows[i].src != 2'd0) begin
                lv(rows[i].src, 1'b1, rows[i].rv);
                cyc(4);
                chk("run", 16'h0001, {15'h0000, run});
                chk("reverse", {15'h0000, rows[i].rv}, {15'h0000, rev});
                rd(`DCS_IDX_STATUS, {14'h0000, rows[i].rv, 1'b1}, "status");
                c0 = coast_seen;
                lv(rows[i].src, 1'b0, 1'b0);
                cyc(5);
                chk("run_off", 16'h0000, {15'h0000, run});
                chk("coast_pulses", 16'(c0 + 1), 16'(coast_seen));
            end
        end
        // out of range and unmapped writes leave the selections alone
        wr(`DCS_IDX_SPEED_SRC, 16'h0004);
        wr(`DCS_IDX_RUN_SRC, 16'h0007);
        wr(`DCS_IDX_STOP_METHOD, 16'h0002);
        wr(12'h1a4, 16'h0000);
        rd(`DCS_IDX_SPEED_SRC, 16'h0003, "speed_src_oor");
        rd(`DCS_IDX_RUN_SRC, 16'h0003, "run_src_oor");
        rd(`DCS_IDX_STOP_METHOD, 16'h0001, "stop_oor");
        // ramp stop with a slow load; writes while running are refused
        wr(`DCS_IDX_RUN_SRC, 16'h0001);
        wr(`DCS_IDX_STOP_METHOD, 16'h0000);
        slow <= 1'b1;
        lv(2'd1, 1'b1, 1'b0);
        cyc(4);
        wr(`DCS_IDX_SPEED_SRC, 16'h0000);
        wr(`DCS_IDX_STOP_METHOD, 16'h0001);
        c0 = coast_seen;
        lv(2'd1, 1'b0, 1'b0);
        cyc(4);
        chk("decel", 16'h0001, {15'h0000, decel});
        chk("run_ramp", 16'h0001, {15'h0000, run});
        wr(`DCS_IDX_RUN_SRC, 16'h0002);
        rd(`DCS_IDX_RUN_SRC, 16'h0001, "run_src_frozen");
        cyc(30);
        chk("run_after_ramp", 16'h0000, {15'h0000, run});
        chk("no_coast", 16'(c0), 16'(coast_seen));
        rd(`DCS_IDX_SPEED_SRC, 16'h0003, "speed_src_frozen");
        rd(`DCS_IDX_STOP_METHOD, 16'h0000, "stop_frozen");
        // panel keys: terminal ignored, direction, run, ramp stop, inch
        slow <= 1'b0;
        wr(`DCS_IDX_RUN_SRC, 16'h0000);
        lv(2'd1, 1'b1, 1'b1);
        cyc(4);
        chk("term_ignored", 16'h0000, {15'h0000, run});
        lv(2'd1, 1'b0, 1'b0);
        press(3'b100);
        press(3'b001);
        cyc(3);
        chk("panel_run", 16'h0001, {15'h0000, run});
        chk("panel_rev", 16'h0001, {15'h0000, rev});
        press(3'b010);
        cyc(10);
        chk("panel_stop", 16'h0000, {15'h0000, run});
        @(posedge mclk);
        inch <= 1'b1;
        cyc(4);
        chk("inch", 16'h0001, {15'h0000, inch_o});
        @(posedge mclk);
        inch <= 1'b0;
        cyc(6);
        chk("inch_off", 16'h0000, {15'h0000, inch_o});
        // mid-run reset: drive drops out and speed source and stop method return to their reset values
        wr(`DCS_IDX_SPEED_SRC, 16'h0001);
        press(3'b001);
        cyc(2);
        chk("run_before_rst", 16'h0001, {15'h0000, run});
        @(posedge mclk);
        srst_in <= 1'b1;
        repeat (2) @(posedge mclk);
        srst_in <= 1'b0;
        #1;
        chk("run_after_rst", 16'h0000, {15'h0000, run});
        rd(`DCS_IDX_SPEED_SRC, 16'h0003, "speed_src_rst2");
        rd(`DCS_IDX_STOP_METHOD, 16'h0001, "stop_rst2");
        give_verdict();
    end
endmodule : drive_command_source_select_bench
